// ===== common/clr_ops_pkg.sv
package clr_ops_pkg;

	// ----------------------------------------
	// instruction encodings (14-bit words)
	// ----------------------------------------
	localparam logic [13:0] clear_watchdog_word = 14'h0064;
	localparam logic [13:0] clear_acc_mask      = 14'h3f80;
	localparam logic [13:0] clear_acc_match     = 14'h0100;

	// ----------------------------------------
	// reset values and constants
	// ----------------------------------------
	localparam logic [7:0] acc_rst_val      = 8'h00;
	localparam logic [7:0] acc_clear_val    = 8'h00;
	localparam logic [7:0] watchdog_rst_val = 8'h00;
	localparam logic [7:0] prescale_rst_val = 8'h00;
	localparam int         phase_count      = 4;

	// ----------------------------------------
	// phase and status types
	// ----------------------------------------
	typedef enum logic [1:0] {
		ph_decode,
		ph_read,
		ph_process,
		ph_write
	} phase_t;

	typedef struct packed {
		logic timeout_status_n;
		logic powerdown_status_n;
		logic zero;
		logic digit_carry;
		logic carry;
	} status_t;

	localparam status_t status_rst_val = 5'h18;

endpackage : clr_ops_pkg

// ===== hw/phase_gen.sv
`timescale 1ns/10ps
module phase_gen
(
	input  wire logic           sys_clk, // core clock
	input  wire logic           arst_n,  // async reset, active low
	output clr_ops_pkg::phase_t phase    // current phase of the instruction cycle
);
	import clr_ops_pkg::*;

	// free-running four-phase sequencer; one instruction per lap, never stalls
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			phase <= ph_decode;
		end else begin
			case (phase)
				ph_decode:  phase <= ph_read;
				ph_read:    phase <= ph_process;
				ph_process: phase <= ph_write;
				ph_write:   phase <= ph_decode;
				default:    phase <= ph_decode;
			endcase
		end
	end

endmodule : phase_gen

// ===== hw/clr_ops_core.sv
`timescale 1ns/10ps
// Summary of operation
// RL1: clear-accumulator: decode, idle, process, then write the accumulator in phase four.
// RL2: clear-accumulator loads zero into the accumulator and sets the zero flag.
// RL3: clear-watchdog zeroes counter and prescaler, sets both active-low status bits.
// RL4: clear-watchdog leaves carry, digit carry and zero flags untouched.
// RL5: clear-watchdog is recognised from the 14-bit word 00 0000 0110 0100.
// RL6: clear-watchdog: decode, idle, process, then clear the counter in phase four.
// RL7: both instructions are one word, one four-phase cycle, no pipeline stall.
module clr_ops_core
(
	input  wire logic             sys_clk,            // 20 MHz core clock
	input  wire logic             arst_n,             // async reset, active low
	input  wire logic [13:0]      instr_word,         // fetched word, held for a whole cycle
	input  wire logic             wdt_tick,           // watchdog time base pulse (same clock)
	output logic [7:0]            acc_reg,            // working register
	output clr_ops_pkg::status_t  status_reg,         // status flags
	output logic [7:0]            watchdog_counter,   // watchdog count
	output logic [7:0]            prescale_reg,       // watchdog prescaler
	output logic                  fetch_advance,      // pulse: next word may be latched
	output logic [1:0]            phase_out           // phase of the previous cycle, registered
);
	import clr_ops_pkg::*;

	// ----------------------------------------
	// phase sequencing
	// ----------------------------------------
	phase_t phase;

	phase_gen phase_gen_i (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.phase   (phase)
	);

	// ----------------------------------------
	// decode functions
	// ----------------------------------------
	// exact match: neighbouring words differ in one bit, so nothing is don't-care
	function automatic logic is_clear_watchdog(input logic [13:0] word);
		return word == clear_watchdog_word;
	endfunction : is_clear_watchdog

	// the low seven bits carry no meaning for the clear-accumulator word
	function automatic logic is_clear_acc(input logic [13:0] word);
		return (word & clear_acc_mask) == clear_acc_match;
	endfunction : is_clear_acc

	// ----------------------------------------
	// decode (latched in phase one)
	// ----------------------------------------
	wire is_clr_wdt = is_clear_watchdog(instr_word);                          // see RL5
	wire is_clr_acc = is_clear_acc(instr_word);
	logic dec_wdt_reg;
	logic dec_acc_reg;
	logic proc_wdt_reg;
	logic proc_acc_reg;

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			dec_wdt_reg <= 1'b0;
			dec_acc_reg <= 1'b0;
		end else if (phase == ph_decode) begin
			dec_wdt_reg <= is_clr_wdt;                                      // see RL1 see RL6
			dec_acc_reg <= is_clr_acc;
		end
	end

	// phase two does nothing; phase three arms the write-back
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			proc_wdt_reg <= 1'b0;
			proc_acc_reg <= 1'b0;
		end else if (phase == ph_process) begin
			proc_wdt_reg <= dec_wdt_reg;
			proc_acc_reg <= dec_acc_reg;
		end else if (phase == ph_write) begin
			proc_wdt_reg <= 1'b0;
			proc_acc_reg <= 1'b0;
		end
	end

	wire write_acc = (phase == ph_write) && proc_acc_reg;                     // see RL1
	wire write_wdt = (phase == ph_write) && proc_wdt_reg;                     // see RL6

	// ----------------------------------------
	// state updates
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc_reg <= acc_rst_val;
		end else if (write_acc) begin
			acc_reg <= acc_clear_val;                                       // see RL2
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			status_reg <= status_rst_val;
		end else if (write_acc) begin
			status_reg.zero <= 1'b1;                                        // see RL2
		end else if (write_wdt) begin
			// only the two active-low bits move; c, dc and z keep their value
			status_reg.timeout_status_n   <= 1'b1;                          // see RL3 see RL4
			status_reg.powerdown_status_n <= 1'b1;                          // see RL3
		end
	end

	// clear wins over a tick landing in the same cycle, so the count restarts at zero
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			watchdog_counter <= watchdog_rst_val;
			prescale_reg     <= prescale_rst_val;
		end else if (write_wdt) begin
			watchdog_counter <= watchdog_rst_val;                           // see RL3
			prescale_reg     <= prescale_rst_val;                           // see RL3
		end else if (wdt_tick) begin
			prescale_reg <= prescale_reg + 8'h01;
			if (prescale_reg == 8'hff) begin
				watchdog_counter <= watchdog_counter + 8'h01;
			end
		end
	end

	// one fetch per lap regardless of instruction: neither op stalls the pipeline
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			fetch_advance <= 1'b0;
			phase_out     <= 2'h0;
		end else begin
			fetch_advance <= (phase == ph_process);                         // see RL7
			phase_out     <= phase;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	acc_clear_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL2
		write_acc |=> (acc_reg == 8'h00) && status_reg.zero)
		else $error("accumulator not cleared with zero flag");

	acc_phase_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL1
		($changed(acc_reg) || $rose(status_reg.zero)) |-> $past(phase) == ph_write)
		else $error("accumulator or zero flag changed outside phase four");

	wdt_status_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		write_wdt |=> status_reg.timeout_status_n && status_reg.powerdown_status_n
			&& watchdog_counter == 8'h00 && prescale_reg == 8'h00)
		else $error("watchdog clear incomplete");

	wdt_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL4
		write_wdt |=> $stable(status_reg.carry) && $stable(status_reg.digit_carry)
			&& $stable(status_reg.zero))
		else $error("watchdog clear touched arithmetic flags");

	wdt_decode_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL5
		(phase == ph_decode && instr_word == 14'h0064) |-> ##3 write_wdt)
		else $error("watchdog word not executed");

	wdt_phase_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL6
		write_wdt |-> phase == ph_write && $past(phase, 3) == ph_decode)
		else $error("watchdog cleared outside phase four");

	fetch_rate_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL7
		fetch_advance |=> !fetch_advance [*3] ##1 fetch_advance)
		else $error("fetch cadence broken");

	// ----------------------------------------
	// decode and sequencing checks
	// ----------------------------------------
	acc_decode_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL1
		(phase == ph_decode && is_clear_acc(instr_word)) |-> ##3 write_acc)
		else $error("clear-accumulator word not executed");

	word_refuse_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL5
		(phase == ph_decode && !is_clear_watchdog(instr_word) && !is_clear_acc(instr_word))
			|-> ##3 !write_wdt && !write_acc)
		else $error("refused word caused a write");

	write_excl_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL5
		!(write_acc && write_wdt))
		else $error("both clear operations in one cycle");

	acc_once_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL7
		write_acc |=> !write_acc [*3])
		else $error("accumulator written twice in one lap");

	wdt_once_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL7
		write_wdt |=> !write_wdt [*3])
		else $error("watchdog cleared twice in one lap");

	phase_copy_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL1
		phase_out == $past(phase))
		else $error("phase output not one cycle behind");

	fetch_phase_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL7
		fetch_advance |-> phase == ph_write)
		else $error("fetch pulse outside phase four");

	// ----------------------------------------
	// status and watchdog side effects
	// ----------------------------------------
	acc_flags_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL2
		write_acc |=> $stable(status_reg.timeout_status_n) && $stable(status_reg.carry)
			&& $stable(status_reg.powerdown_status_n) && $stable(status_reg.digit_carry))
		else $error("accumulator clear touched other flags");

	wdt_idle_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL6
		(!write_wdt && !wdt_tick) |=> $stable(prescale_reg) && $stable(watchdog_counter))
		else $error("watchdog moved without tick or clear");

	tick_count_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		(wdt_tick && !write_wdt) |=> prescale_reg == $past(prescale_reg) + 8'h01)
		else $error("prescaler missed a tick");

	counter_bump_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		(wdt_tick && !write_wdt && prescale_reg == 8'hff)
			|=> watchdog_counter == $past(watchdog_counter) + 8'h01)
		else $error("counter missed a prescaler wrap");

	clear_wins_a: assert property (@(posedge sys_clk) disable iff (!arst_n) // see RL3
		(write_wdt && wdt_tick) |=> prescale_reg == prescale_rst_val)
		else $error("tick beat the watchdog clear");

endmodule : clr_ops_core

// ===== verif/clr_ops_core_test.sv
`timescale 1ns/10ps
module clr_ops_core_test;
	import clr_ops_pkg::*;
	logic        sys_clk    = 1'b0;
	logic        arst_n     = 1'b0;
	logic [13:0] instr_word = 14'h0000;
	logic        wdt_tick   = 1'b0;
	logic [7:0]  acc_reg, watchdog_counter, prescale_reg;
	status_t     status_reg;
	logic        fetch_advance;
	logic [1:0]  phase_out;
	int          cyc, fa_count, num_errors, cmp_count;
	logic [13:0] w;

	clr_ops_core clr_ops_core_i (.sys_clk(sys_clk), .arst_n(arst_n), .instr_word(instr_word),
		.wdt_tick(wdt_tick), .acc_reg(acc_reg), .status_reg(status_reg),
		.watchdog_counter(watchdog_counter), .prescale_reg(prescale_reg),
		.fetch_advance(fetch_advance), .phase_out(phase_out));

	always #25 sys_clk = ~sys_clk;
	// own cycle count keeps the word aligned to decode edges without trusting phase_out
	always @(posedge sys_clk) begin
		cyc <= arst_n ? cyc + 1 : 0;
		if (fetch_advance === 1'b1) fa_count <= fa_count + 1;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk
	task do_reset;
		@(posedge sys_clk);
		arst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
	endtask : do_reset
	// word lands on the edge before a decode edge; results checked after the write edge
	// a set tick_in_write makes a prescaler tick coincide with the write edge
	task issue(input logic [13:0] word, input logic tick_in_write);
		do @(posedge sys_clk); while (cyc % 4 != 3);
		instr_word <= word;
		repeat (3) @(posedge sys_clk);
		wdt_tick <= tick_in_write;
		@(posedge sys_clk);
		instr_word <= 14'h0000;
		wdt_tick <= 1'b0;
		@(negedge sys_clk);
	endtask : issue
	task ticks(input int n);
		repeat (n) begin
			@(posedge sys_clk) wdt_tick <= 1'b1;
			@(posedge sys_clk) wdt_tick <= 1'b0;
		end
	endtask : ticks

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		do_reset();
		@(negedge sys_clk);
		chk("acc", 8'h00, acc_reg);
		chk("status", 8'h18, 8'(status_reg));
		chk("counter", 8'h00, watchdog_counter);
		chk("prescale", 8'h00, prescale_reg);
		chk("fetch", 8'h00, 8'(fetch_advance));
		chk("phase", 8'h00, 8'(phase_out));
		$display("test reset done");
	endtask : t_reset
	task t_clear_acc;
		int n;
		for (int i = 0; i < 3; i++) begin
			w = (i == 0) ? 14'h0100 : (i == 1) ? 14'h017f : 14'h0155;
			issue(w, 1'b0);
			chk("acc", 8'h00, acc_reg);
			chk("status", 8'h1c, 8'(status_reg));
			chk("phase", 8'h03, 8'(phase_out));
			chk("fetch", 8'h00, 8'(fetch_advance));
		end
		do @(posedge sys_clk); while (cyc % 4 != 3);
		instr_word <= 14'h0100;
		n = fa_count;
		repeat (16) @(posedge sys_clk);
		chk("fetch pulses", 8'h04, 8'(fa_count - n));
		instr_word <= 14'h0000;
		$display("test clear acc done");
	endtask : t_clear_acc
	task t_clear_wdt;
		do_reset();
		ticks(257);
		@(negedge sys_clk);
		chk("counter", 8'h01, watchdog_counter);
		chk("prescale", 8'h01, prescale_reg);
		issue(14'h0064, 1'b0);
		chk("counter", 8'h00, watchdog_counter);
		chk("prescale", 8'h00, prescale_reg);
		chk("status", 8'h18, 8'(status_reg));
		issue(14'h0100, 1'b0);
		ticks(3);
		@(negedge sys_clk);
		chk("prescale", 8'h03, prescale_reg);
		// a tick on the write edge must not survive the clear
		issue(14'h0064, 1'b1);
		chk("prescale", 8'h00, prescale_reg);
		chk("counter", 8'h00, watchdog_counter);
		chk("status", 8'h1c, 8'(status_reg));
		$display("test clear watchdog done");
	endtask : t_clear_wdt
	task t_refused;
		do_reset();
		ticks(3);
		for (int i = 0; i < 4; i++) begin
			w = (i == 0) ? 14'h0063 : (i == 1) ? 14'h0065 : (i == 2) ? 14'h0180 : 14'h0044;
			issue(w, 1'b0);
			chk("prescale", 8'h03, prescale_reg);
			chk("status", 8'h18, 8'(status_reg));
		end
		$display("test refused words done");
	endtask : t_refused

	task final_report;
		$display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	initial begin
		t_reset();
		t_clear_acc();
		t_clear_wdt();
		t_refused();
		final_report();
	end
	// about 700 cycles expected; this allows eight times that
	initial begin
		#300000;
		num_errors++;
		final_report();
	end
endmodule : clr_ops_core_test
